// [pwm_cfg_map.svh]
`ifndef PWM_CFG_MAP_SVH
`define PWM_CFG_MAP_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_LOOP_COMP       8'hD3
`define CMD_PHASE_CFG       8'hF5
`define CMD_FREQ_SWITCH     8'h33

// ----------------------------------------
// reset values
// ----------------------------------------
`define LOOP_COMP_RESET     8'h70
`define PHASE_CFG_RESET     8'h10
`define FREQ_SWITCH_RESET   16'hF3E8

// ----------------------------------------
// field positions
// ----------------------------------------
`define COMP_GM_MSB         7
`define COMP_GM_LSB         5
`define COMP_RES_MSB        4
`define COMP_RES_LSB        0
`define PH_FB_SHARE_BIT     7
`define PH_GAIN_MSB         6
`define PH_GAIN_LSB         5
`define PH_SHARE_CLK_BIT    4
`define PH_RSVD_BIT         3
`define PH_OFFSET_MSB       2
`define PH_OFFSET_LSB       0
`define PH_OFFSET_RSVD      3'h7
`define PH_GAIN_RSVD        2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS       50
`define PLL_LOCK_US         100
`define PLL_LOCK_CYC        ((`PLL_LOCK_US * 1000) / `CLK_PERIOD_NS)

`endif

// [pwm_cfg_pkg.sv]
package pwm_cfg_pkg;

   // ----------------------------------------
   // decoder state
   // ----------------------------------------
   typedef struct packed {
      logic [9:0] gm_10us;
      logic [7:0] res_quarter_k;
   } comp_dec_st_t;

   // ----------------------------------------
   // configuration block state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  comp_p0;
      logic [7:0]  comp_p1;
      logic [7:0]  phase_cfg;
      logic [15:0] freq;
      logic        busy_fault;
      logic        cml_fault;
      logic        resp_valid;
      logic        resp_nack;
      logic [15:0] resp_rdata;
      logic [8:0]  ch0_phase;
      logic [8:0]  ch1_phase;
      logic        vin_ok;
      logic        ever_on;
      logic        share_clk_low;
      logic        pll_unlock;
      logic [11:0] pll_cnt;
   } cfg_st_t;

endpackage

// [comp_decode.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pwm_cfg_map.svh"

module comp_decode (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // compensation byte
   input  wire logic [7:0] comp_code,
   // decoded loop settings
   output logic      [9:0] gm_10us,
   output logic      [7:0] res_quarter_k
);

   pwm_cfg_pkg::comp_dec_st_t st;
   pwm_cfg_pkg::comp_dec_st_t next_st;

   always_comb begin
      next_st = st;
      // [RULE1] transconductance lookup
      case (comp_code[`COMP_GM_MSB:`COMP_GM_LSB])
         3'h0:    next_st.gm_10us = 10'h064;
         3'h1:    next_st.gm_10us = 10'h0A8;
         3'h2:    next_st.gm_10us = 10'h0EB;
         3'h3:    next_st.gm_10us = 10'h12E;
         3'h4:    next_st.gm_10us = 10'h171;
         3'h5:    next_st.gm_10us = 10'h1B4;
         3'h6:    next_st.gm_10us = 10'h1F8;
         default: next_st.gm_10us = 10'h23D;
      endcase
      // [RULE2] resistor lookup, quarter kilohm
      case (comp_code[`COMP_RES_MSB:`COMP_RES_LSB])
         5'h00:   next_st.res_quarter_k = 8'h00;
         5'h01:   next_st.res_quarter_k = 8'h01;
         5'h02:   next_st.res_quarter_k = 8'h02;
         5'h03:   next_st.res_quarter_k = 8'h03;
         5'h04:   next_st.res_quarter_k = 8'h04;
         5'h05:   next_st.res_quarter_k = 8'h05;
         5'h06:   next_st.res_quarter_k = 8'h06;
         5'h07:   next_st.res_quarter_k = 8'h07;
         5'h08:   next_st.res_quarter_k = 8'h08;
         5'h09:   next_st.res_quarter_k = 8'h0A;
         5'h0A:   next_st.res_quarter_k = 8'h0C;
         5'h0B:   next_st.res_quarter_k = 8'h0E;
         5'h0C:   next_st.res_quarter_k = 8'h10;
         5'h0D:   next_st.res_quarter_k = 8'h12;
         5'h0E:   next_st.res_quarter_k = 8'h14;
         5'h0F:   next_st.res_quarter_k = 8'h16;
         5'h10:   next_st.res_quarter_k = 8'h18;
         5'h11:   next_st.res_quarter_k = 8'h1C;
         5'h12:   next_st.res_quarter_k = 8'h20;
         5'h13:   next_st.res_quarter_k = 8'h24;
         5'h14:   next_st.res_quarter_k = 8'h2C;
         5'h15:   next_st.res_quarter_k = 8'h34;
         5'h16:   next_st.res_quarter_k = 8'h3C;
         5'h17:   next_st.res_quarter_k = 8'h44;
         5'h18:   next_st.res_quarter_k = 8'h50;
         5'h19:   next_st.res_quarter_k = 8'h60;
         5'h1A:   next_st.res_quarter_k = 8'h70;
         5'h1B:   next_st.res_quarter_k = 8'h80;
         5'h1C:   next_st.res_quarter_k = 8'h98;
         5'h1D:   next_st.res_quarter_k = 8'hB8;
         5'h1E:   next_st.res_quarter_k = 8'hD8;
         default: next_st.res_quarter_k = 8'hF8;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign gm_10us       = st.gm_10us;
   assign res_quarter_k = st.res_quarter_k;

endmodule

`default_nettype wire

// [pwm_loop_phase_freq_config.sv]
// What this block does
// [RULE1] upper three compensation bits pick error-amp transconductance, 1.00 to 5.73 mS
// [RULE2] lower five compensation bits pick internal resistor, 0 to 62 kilohm
// [RULE3] phase byte bit 7 set makes channel 1 use channel 0 feedback
// [RULE4] host sets feedback sharing only for multi-phase, with shared connections
// [RULE5] bits 6:5 pick input sense gain 2x, 4x, 8x; code 11 forbidden
// [RULE6] low three phase bits pick channel 0 and 1 phase offsets
// [RULE7] phase byte write while a channel runs is NACKed with busy fault
// [RULE8] shared-clock bit controls pulling the shared clock low on input thresholds
// [RULE9] host writes switching frequency only within 85 to 500 kHz
// [RULE10] frequency write while running is NACKed with busy fault
// [RULE11] after an accepted frequency change, report loss of lock until settled
// [RULE12] loop compensation is paged byte command 0xD3, reset 0x70
// [RULE13] phase configuration is unpaged byte command 0xF5, reset 0x10
// [RULE14] switching frequency is unpaged word command 0x33, L11, reset 250 kHz
// [RULE15] bit 3 and phase code 111 reserved; code 111 write flags fault
`timescale 1ns/10ps
`default_nettype none
`include "pwm_cfg_map.svh"

module pwm_loop_phase_freq_config (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // command request
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        cmd_page,
   input  wire logic [15:0] cmd_wdata,
   // command answer
   output logic             resp_valid,
   output logic             resp_nack,
   output logic [15:0]      resp_rdata,
   // fault flags
   input  wire logic        fault_clear,
   output logic             busy_fault,
   output logic             cml_fault,
   // channel state
   input  wire logic [1:0]  run_pin,
   input  wire logic [1:0]  ch_cmd_on,
   // input voltage comparators
   input  wire logic        vin_above_on,
   input  wire logic        vin_below_off,
   // loop settings
   output logic [9:0]       ch0_error_amp_transconductance,
   output logic [7:0]       ch0_internal_comp_resistor,
   output logic [9:0]       ch1_error_amp_transconductance,
   output logic [7:0]       ch1_internal_comp_resistor,
   // phase and sense settings
   output logic             use_ch0_feedback_node,
   output logic [1:0]       input_sense_gain,
   output logic [8:0]       ch0_phase_deg,
   output logic [8:0]       ch1_phase_deg,
   output logic             share_clk_low,
   // frequency
   output logic [15:0]      freq_setting,
   output logic             pll_unlock
);

   pwm_cfg_pkg::cfg_st_t st;
   pwm_cfg_pkg::cfg_st_t next_st;

   logic       running;
   logic       wr;
   logic [7:0] wbyte;

   assign running = |(run_pin & ch_cmd_on);
   assign wr      = cmd_valid & cmd_write;
   assign wbyte   = cmd_wdata[7:0];

   // ----------------------------------------
   // command decode and state update
   // ----------------------------------------
   always_comb begin
      next_st            = st;
      next_st.resp_valid = cmd_valid;
      next_st.resp_nack  = 1'b0;
      next_st.resp_rdata = 16'h0000;
      if (fault_clear) begin
         next_st.busy_fault = 1'b0;
         next_st.cml_fault  = 1'b0;
      end
      if (cmd_valid) begin
         case (cmd_code)
            // [RULE12] paged compensation byte
            `CMD_LOOP_COMP: begin
               if (cmd_write && cmd_page) begin
                  next_st.comp_p1 = wbyte;
               end else if (cmd_write) begin
                  next_st.comp_p0 = wbyte;
               end else begin
                  next_st.resp_rdata = {8'h00, cmd_page ? st.comp_p1 : st.comp_p0};
               end
            end
            // [RULE13] unpaged phase byte
            `CMD_PHASE_CFG: begin
               if (!cmd_write) begin
                  next_st.resp_rdata = {8'h00, st.phase_cfg};
               // [RULE7] refuse while running
               end else if (running) begin
                  next_st.resp_nack  = 1'b1;
                  next_st.busy_fault = 1'b1;
               // [RULE15] reserved phase code
               end else if (wbyte[`PH_OFFSET_MSB:`PH_OFFSET_LSB] == `PH_OFFSET_RSVD ||
                            // [RULE5] forbidden gain code
                            wbyte[`PH_GAIN_MSB:`PH_GAIN_LSB] == `PH_GAIN_RSVD) begin
                  next_st.resp_nack = 1'b1;
                  next_st.cml_fault = 1'b1;
               end else begin
                  // [RULE15] reserved bit stored as zero
                  next_st.phase_cfg = wbyte & ~(8'h01 << `PH_RSVD_BIT);
               end
            end
            // [RULE14] unpaged frequency word
            `CMD_FREQ_SWITCH: begin
               if (!cmd_write) begin
                  next_st.resp_rdata = st.freq;
               // [RULE10] refuse while running
               end else if (running) begin
                  next_st.resp_nack  = 1'b1;
                  next_st.busy_fault = 1'b1;
               end else begin
                  // range check is the host's duty; the word is kept as written
                  next_st.freq = cmd_wdata;
                  // [RULE11] unlock until resettled
                  if (cmd_wdata != st.freq) begin
                     next_st.pll_unlock = 1'b1;
                     next_st.pll_cnt    = 12'(`PLL_LOCK_CYC);
                  end
               end
            end
            default: begin
               next_st.resp_nack = 1'b1;
               next_st.cml_fault = 1'b1;
            end
         endcase
      end

      // [RULE11] settle countdown
      if (st.pll_unlock && !(wr && cmd_code == `CMD_FREQ_SWITCH && !running)) begin
         if (st.pll_cnt == 12'h000) begin
            next_st.pll_unlock = 1'b0;
         end else begin
            next_st.pll_cnt = st.pll_cnt - 12'h001;
         end
      end

      // [RULE6] phase offset table
      case (next_st.phase_cfg[`PH_OFFSET_MSB:`PH_OFFSET_LSB])
         3'h0:    {next_st.ch0_phase, next_st.ch1_phase} = {9'h000, 9'h0B4};
         3'h1:    {next_st.ch0_phase, next_st.ch1_phase} = {9'h05A, 9'h10E};
         3'h2:    {next_st.ch0_phase, next_st.ch1_phase} = {9'h000, 9'h0F0};
         3'h3:    {next_st.ch0_phase, next_st.ch1_phase} = {9'h000, 9'h078};
         3'h4:    {next_st.ch0_phase, next_st.ch1_phase} = {9'h078, 9'h0F0};
         3'h5:    {next_st.ch0_phase, next_st.ch1_phase} = {9'h03C, 9'h0F0};
         3'h6:    {next_st.ch0_phase, next_st.ch1_phase} = {9'h078, 9'h12C};
         default: {next_st.ch0_phase, next_st.ch1_phase} = {st.ch0_phase, st.ch1_phase};
      endcase

      // [RULE8] input window and shared clock pull-down
      if (vin_above_on) begin
         next_st.vin_ok  = 1'b1;
         next_st.ever_on = 1'b1;
      end else if (vin_below_off) begin
         next_st.vin_ok = 1'b0;
      end
      // with the bit clear only the start-up hold remains
      next_st.share_clk_low = next_st.phase_cfg[`PH_SHARE_CLK_BIT] ? !next_st.vin_ok
                                                                  : !next_st.ever_on;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st               <= '0;
         st.comp_p0       <= `LOOP_COMP_RESET;
         st.comp_p1       <= `LOOP_COMP_RESET;
         st.phase_cfg     <= `PHASE_CFG_RESET;
         st.freq          <= `FREQ_SWITCH_RESET;
         st.ch1_phase     <= 9'h0B4;
         st.share_clk_low <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // per-page loop decoders
   // ----------------------------------------
   comp_decode u_comp0 (
      .core_clk      (core_clk),
      .reset         (reset),
      .comp_code     (st.comp_p0),
      .gm_10us       (ch0_error_amp_transconductance),
      .res_quarter_k (ch0_internal_comp_resistor)
   );

   comp_decode u_comp1 (
      .core_clk      (core_clk),
      .reset         (reset),
      .comp_code     (st.comp_p1),
      .gm_10us       (ch1_error_amp_transconductance),
      .res_quarter_k (ch1_internal_comp_resistor)
   );

   assign resp_valid            = st.resp_valid;
   assign resp_nack             = st.resp_nack;
   assign resp_rdata            = st.resp_rdata;
   assign busy_fault            = st.busy_fault;
   assign cml_fault             = st.cml_fault;
   // [RULE3] feedback sharing select
   assign use_ch0_feedback_node = st.phase_cfg[`PH_FB_SHARE_BIT];
   // [RULE5] sense gain code
   assign input_sense_gain      = st.phase_cfg[`PH_GAIN_MSB:`PH_GAIN_LSB];
   assign ch0_phase_deg         = st.ch0_phase;
   assign ch1_phase_deg         = st.ch1_phase;
   assign share_clk_low         = st.share_clk_low;
   assign freq_setting          = st.freq;
   assign pll_unlock            = st.pll_unlock;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_phase_wr;
      wr && cmd_code == `CMD_PHASE_CFG;
   endsequence

   sequence s_phase_ok;
      s_phase_wr ##0 (!running && cmd_wdata[2:0] != 3'h7 && cmd_wdata[6:5] != 2'h3);
   endsequence

   property p_phase_busy;
      @(posedge core_clk) disable iff (reset)
      s_phase_wr ##0 running |=> resp_valid && resp_nack && busy_fault && st.phase_cfg == $past(st.phase_cfg);
   endproperty
   a_phase_busy: assert property (p_phase_busy) else $error("phase write not refused while running"); // [RULE7]

   property p_freq_busy;
      @(posedge core_clk) disable iff (reset)
      wr && cmd_code == `CMD_FREQ_SWITCH && running |=> resp_nack && busy_fault && freq_setting == $past(freq_setting);
   endproperty
   a_freq_busy: assert property (p_freq_busy) else $error("frequency write not refused while running"); // [RULE10]

   property p_rsvd_phase;
      @(posedge core_clk) disable iff (reset)
      s_phase_wr ##0 (!running && cmd_wdata[2:0] == 3'h7) |=> cml_fault && resp_nack && ch0_phase_deg == $past(ch0_phase_deg);
   endproperty
   a_rsvd_phase: assert property (p_rsvd_phase) else $error("reserved phase code accepted"); // [RULE15]

   property p_gain_rsvd;
      @(posedge core_clk) disable iff (reset)
      s_phase_wr ##0 (!running && cmd_wdata[6:5] == 2'h3) |=> cml_fault && input_sense_gain != 2'h3;
   endproperty
   a_gain_rsvd: assert property (p_gain_rsvd) else $error("forbidden gain code stored"); // [RULE5]

   property p_fb_share;
      @(posedge core_clk) disable iff (reset)
      s_phase_ok |=> !resp_nack && use_ch0_feedback_node == $past(cmd_wdata[7]);
   endproperty
   a_fb_share: assert property (p_fb_share) else $error("feedback share bit not taken"); // [RULE3]

   property p_phase_90;
      @(posedge core_clk) disable iff (reset)
      s_phase_ok ##0 cmd_wdata[2:0] == 3'h1 |=> ch0_phase_deg == 9'h05A && ch1_phase_deg == 9'h10E;
   endproperty
   a_phase_90: assert property (p_phase_90) else $error("phase code 1 gives wrong offsets"); // [RULE6]

   property p_gm_top;
      @(posedge core_clk) disable iff (reset)
      wr && cmd_code == `CMD_LOOP_COMP && !cmd_page && cmd_wdata[7:5] == 3'h7 ##1 1'b1
         |=> ch0_error_amp_transconductance == 10'h23D;
   endproperty
   a_gm_top: assert property (p_gm_top) else $error("top gm code not decoded"); // [RULE1]

   property p_res_top;
      @(posedge core_clk) disable iff (reset)
      wr && cmd_code == `CMD_LOOP_COMP && cmd_page && cmd_wdata[4:0] == 5'h1F ##1 1'b1
         |=> ch1_internal_comp_resistor == 8'hF8;
   endproperty
   a_res_top: assert property (p_res_top) else $error("top resistor code not decoded"); // [RULE2]

   property p_unlock;
      @(posedge core_clk) disable iff (reset)
      wr && cmd_code == `CMD_FREQ_SWITCH && !running && cmd_wdata != freq_setting |=> pll_unlock [*8];
   endproperty
   a_unlock: assert property (p_unlock) else $error("no unlock after frequency change"); // [RULE11]

   property p_share_clk;
      @(posedge core_clk) disable iff (reset)
      st.phase_cfg[4] && !(wr && cmd_code == `CMD_PHASE_CFG) && vin_below_off && !vin_above_on |=> share_clk_low;
   endproperty
   a_share_clk: assert property (p_share_clk) else $error("shared clock not pulled low"); // [RULE8]

endmodule

`default_nettype wire

// [pwm_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pwm_cfg_map.svh"

module pwm_host_model #(
   parameter bit MULTI_PHASE = 1'b0
) (
   // clock
   input  wire logic        core_clk,
   // command request
   output logic             cmd_valid,
   output logic             cmd_write,
   output logic [7:0]       cmd_code,
   output logic             cmd_page,
   output logic [15:0]      cmd_wdata,
   // command answer
   input  wire logic        resp_valid,
   input  wire logic        resp_nack,
   input  wire logic [15:0] resp_rdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      cmd_page  = 1'b0;
      cmd_wdata = 16'h0000;
   end

   // ----------------------------------------
   // one command, answer awaited for a few edges
   // ----------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] wd,
                       output logic nack, output logic [15:0] rd);
      logic [15:0] w;
      int          n;
      w = wd;
      if (code == `CMD_PHASE_CFG && !MULTI_PHASE)
         w[7] = 1'b0;
      if (code == `CMD_PHASE_CFG && w[6:5] == 2'h3)
         w[6:5] = 2'h0;
      if (code == `CMD_FREQ_SWITCH)
         w = (w[10:0] < 11'h055) ? 16'h0055 : (w[10:0] > 11'h1F4) ? 16'h01F4 : {5'h00, w[10:0]};
      nack = 1'bx;
      rd = 16'hXXXX;
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_code  <= code;
      cmd_page  <= pg;
      cmd_wdata <= w;
      @(posedge core_clk);
      // released lines show a changed pattern, not the last value
      cmd_valid <= 1'b0;
      cmd_write <= ~wr;
      cmd_code  <= ~code;
      cmd_page  <= ~pg;
      cmd_wdata <= ~w;
      for (n = 0; n < 4; n++) begin
         @(posedge core_clk);
         if (resp_valid === 1'b1) begin
            nack = resp_nack;
            rd = resp_rdata;
            break;
         end
      end
   endtask
endmodule

`default_nettype wire

// [tb_pwm_loop_phase_freq_config.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pwm_cfg_map.svh"

module tb_pwm_loop_phase_freq_config;
   typedef struct packed {
      logic [7:0] data;
      logic [8:0] p0;
      logic [8:0] p1;
   } ph_row_t;

   logic        core_clk, reset, cmd_valid, cmd_write, cmd_page, fault_clear, vin_above_on, vin_below_off;
   logic [7:0]  cmd_code, res0, res1;
   logic [15:0] cmd_wdata, resp_rdata, freq_setting, rd;
   logic        resp_valid, resp_nack, busy_fault, cml_fault, use_fb, share_clk_low, pll_unlock, nack;
   logic [1:0]  run_pin, ch_cmd_on, gain;
   logic [9:0]  gm0, gm1;
   logic [8:0]  ph0, ph1;
   logic [9:0]  egm [2];
   logic [7:0]  eres [2];
   logic [7:0]  b;
   int          bad_count, checked, cycles, cnt;
   logic [9:0]  gm_tab [8] = '{10'h064, 10'h0A8, 10'h0EB, 10'h12E, 10'h171, 10'h1B4, 10'h1F8, 10'h23D};
   logic [7:0]  res_tab [32] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0C,
      8'h0E, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h2C, 8'h34, 8'h3C, 8'h44, 8'h50,
      8'h60, 8'h70, 8'h80, 8'h98, 8'hB8, 8'hD8, 8'hF8};
   ph_row_t     ph_rows [7] = '{'{8'h00, 9'h000, 9'h0B4}, '{8'hA1, 9'h05A, 9'h10E}, '{8'h42, 9'h000, 9'h0F0},
      '{8'h2B, 9'h000, 9'h078}, '{8'h94, 9'h078, 9'h0F0}, '{8'h05, 9'h03C, 9'h0F0}, '{8'hC6, 9'h078, 9'h12C}};

   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;

   pwm_host_model #(.MULTI_PHASE(1'b1)) host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
      .resp_nack(resp_nack), .resp_rdata(resp_rdata));

   pwm_loop_phase_freq_config uut (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
      .resp_valid(resp_valid), .resp_nack(resp_nack), .resp_rdata(resp_rdata), .fault_clear(fault_clear),
      .busy_fault(busy_fault), .cml_fault(cml_fault), .run_pin(run_pin), .ch_cmd_on(ch_cmd_on),
      .vin_above_on(vin_above_on), .vin_below_off(vin_below_off), .ch0_error_amp_transconductance(gm0),
      .ch0_internal_comp_resistor(res0), .ch1_error_amp_transconductance(gm1), .ch1_internal_comp_resistor(res1),
      .use_ch0_feedback_node(use_fb), .input_sense_gain(gain), .ch0_phase_deg(ph0), .ch1_phase_deg(ph1),
      .share_clk_low(share_clk_low), .freq_setting(freq_setting), .pll_unlock(pll_unlock));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      if (bad_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // levels change at an edge, then settle for two edges
   task automatic drive(input logic [1:0] pins, input logic [1:0] on, input logic above, input logic below);
      @(posedge core_clk);
      run_pin <= pins;
      ch_cmd_on <= on;
      vin_above_on <= above;
      vin_below_off <= below;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   // a hang costs a mismatch rather than the run
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles > 12000) begin
         bad_count++;
         end_sim;
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {reset, fault_clear, vin_above_on, vin_below_off, run_pin, ch_cmd_on} = 8'h80;
      {bad_count, checked, cycles} = '0;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check(16'(gm0), 16'h012E);
      check(16'(res1), 16'h0018);
      check({ph0, ph1[6:0]}, {9'h000, 7'h34});
      check({13'h0000, use_fb, gain}, 16'h0000);
      check({14'h0000, share_clk_low, pll_unlock}, 16'h0002);
      host.xfer(1'b0, `CMD_LOOP_COMP, 1'b1, 16'h0000, nack, rd);
      check(rd, 16'h0070);
      host.xfer(1'b0, `CMD_PHASE_CFG, 1'b0, 16'h0000, nack, rd);
      check(rd, 16'h0010);
      host.xfer(1'b0, `CMD_FREQ_SWITCH, 1'b0, 16'h0000, nack, rd);
      check(rd, 16'hF3E8);
      foreach (ph_rows[i]) begin
         host.xfer(1'b1, `CMD_PHASE_CFG, 1'b0, {8'h00, ph_rows[i].data}, nack, rd);
         #1;
         check(16'(nack), 16'h0000);
         check({ph0, ph1[6:0]}, {ph_rows[i].p0, ph_rows[i].p1[6:0]});
         check(16'(ph1), 16'(ph_rows[i].p1));
         check({13'h0000, use_fb, gain}, {13'h0000, ph_rows[i].data[7:5]});
         host.xfer(1'b0, `CMD_PHASE_CFG, 1'b0, 16'h0000, nack, rd);
         check(rd, {8'h00, ph_rows[i].data & 8'hF7});
      end
      egm = '{10'h12E, 10'h12E};
      eres = '{8'h18, 8'h18};
      for (int i = 0; i < 32; i++) begin
         b = {i[3:1], i[4:0]};
         host.xfer(1'b1, `CMD_LOOP_COMP, i[0], {8'h00, b}, nack, rd);
         egm[i[0]] = gm_tab[i[3:1]];
         eres[i[0]] = res_tab[i];
         @(posedge core_clk);
         #1;
         check({gm0, 6'h00}, {egm[0], 6'h00});
         check({gm1, res1[5:0]}, {egm[1], eres[1][5:0]});
         check({res0, res1}, {eres[0], eres[1]});
         host.xfer(1'b0, `CMD_LOOP_COMP, i[0], 16'h0000, nack, rd);
         check(rd, {8'h00, b});
      end
      drive(2'b10, 2'b10, 1'b0, 1'b0);
      host.xfer(1'b1, `CMD_PHASE_CFG, 1'b0, 16'h0001, nack, rd);
      #1;
      check({14'h0000, nack, busy_fault}, 16'h0003);
      check(16'(ph1), 16'h012C);
      host.xfer(1'b1, `CMD_FREQ_SWITCH, 1'b0, 16'h0064, nack, rd);
      #1;
      check({15'h0000, nack}, 16'h0001);
      check(freq_setting, 16'hF3E8);
      @(posedge core_clk);
      fault_clear <= 1'b1;
      @(posedge core_clk);
      fault_clear <= 1'b0;
      drive(2'b11, 2'b00, 1'b0, 1'b0);
      host.xfer(1'b1, `CMD_PHASE_CFG, 1'b0, 16'h0007, nack, rd);
      #1;
      check({13'h0000, nack, busy_fault, cml_fault}, 16'h0005);
      check(16'(ph1), 16'h012C);
      host.xfer(1'b1, `CMD_PHASE_CFG, 1'b0, 16'h0010, nack, rd);
      #1;
      check({nack, 6'h00, ph1}, 16'h00B4);
      drive(2'b00, 2'b11, 1'b0, 1'b0);
      host.xfer(1'b1, `CMD_FREQ_SWITCH, 1'b0, 16'h0064, nack, rd);
      #1;
      check({15'h0000, nack}, 16'h0000);
      check(freq_setting, 16'h0064);
      cnt = 1;
      while (pll_unlock === 1'b1 && cnt < 3000) begin
         cnt++;
         @(posedge core_clk);
         #1;
      end
      check(16'(cnt), 16'(`PLL_LOCK_CYC + 1));
      host.xfer(1'b1, `CMD_FREQ_SWITCH, 1'b0, 16'h0064, nack, rd);
      #1;
      check({15'h0000, pll_unlock}, 16'h0000);
      check({14'h0000, share_clk_low, vin_above_on}, 16'h0002);
      drive(2'b00, 2'b00, 1'b1, 1'b0);
      check(16'(share_clk_low), 16'h0000);
      drive(2'b00, 2'b00, 1'b0, 1'b1);
      check(16'(share_clk_low), 16'h0001);
      host.xfer(1'b1, `CMD_PHASE_CFG, 1'b0, 16'h0000, nack, rd);
      drive(2'b00, 2'b00, 1'b0, 1'b1);
      check(16'(share_clk_low), 16'h0000);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check({5'h00, cml_fault, share_clk_low, ph1}, 16'h02B4);
      check(freq_setting, 16'hF3E8);
      host.xfer(1'b0, 8'h00, 1'b0, 16'h0000, nack, rd);
      #1;
      check({14'h0000, nack, cml_fault}, 16'h0003);
      end_sim;
   end
endmodule

`default_nettype wire
